// >>> hw/fcb_pkg.sv
// Constants, opcodes, register addresses and field layout of the
// command-behaviour configuration block of a serial flash.
// Assumes a mode 0/3 SPI frame of opcode, 24-bit address and data bytes.
// Contract
// - Blank check on: erase unconditionally if sector's last erase failed
// - Last erase good: scan sector, erase on first zero, else skip erase
// - Blank check covers parameter, sector, bulk erase; off means erase now
// - Wrap bit clear: page load wraps at 256 bytes; set: 512 bytes
// - Map bit clear: 4-KB parameter sectors present; set: uniform sectors
// - Volatile map bit is read-only, follows its boot copy only
// - Opcode 30h is resume when select bit is 1, clear status when 0
// - Single-byte F0h resets only when legacy reset enable is 1
// - Sequence 66h then 99h always performs a software reset
// - Burst wrap affects main array reads only, never register or OTP
// - Any reset copies boot burst and drive setting into live copy
// - Set-burst-length command also writes the live burst register
// - Registers are read with 65h and written with 71h
// - Wrap enable is active low, for quad I/O and DDR quad I/O reads
// - Wrap length 00/01/10/11 gives 8/16/32/64 bytes length and alignment
// - Drive strength in bits 7:5, default 000, live copy adjustable
// - Boot command copy supplies reset values of live command register
package fcb_pkg;
	localparam int ADDR_BYTES = 3;
	localparam int ADDR_W = 8 * ADDR_BYTES;
	localparam logic [7:0] OP_READ_ANY = 8'h65;
	localparam logic [7:0] OP_WRITE_ANY = 8'h71;
	localparam logic [7:0] OP_SET_BURST = 8'hc0;
	localparam logic [7:0] OP_RESUME_CLEAR = 8'h30;
	localparam logic [7:0] OP_LEGACY_RESET = 8'hf0;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [7:0] OP_ERASE_PARAM = 8'h20;
	localparam logic [7:0] OP_ERASE_SECTOR = 8'hd8;
	localparam logic [7:0] OP_ERASE_BULK = 8'h60;
	localparam logic [ADDR_W-1:0] ADDR_CMD_BOOT = 24'h000004;
	localparam logic [ADDR_W-1:0] ADDR_BURST_BOOT = 24'h000005;
	localparam logic [ADDR_W-1:0] ADDR_CMD_LIVE = 24'h800004;
	localparam logic [ADDR_W-1:0] ADDR_BURST_LIVE = 24'h800005;
	localparam logic [7:0] CMD_CFG_MASK = 8'h3d;
	localparam logic [7:0] BURST_CFG_MASK = 8'hf3;
	localparam int BIT_BLANK_CHECK = 5;
	localparam int BIT_PAGE_WRAP = 4;
	localparam int BIT_SECTOR_MAP = 3;
	localparam int BIT_RESUME_SEL = 2;
	localparam int BIT_LEGACY_RST = 0;
	localparam int BIT_WRAP_OFF = 4;
	localparam int DRIVE_LSB = 5;
	localparam int DRIVE_W = 3;
	localparam int WRAP_LEN_W = 2;
	localparam logic [7:0] CMD_CFG_BOOT_RESET = 8'h00;
	localparam logic [7:0] BURST_CFG_BOOT_RESET = 8'h10;
	localparam logic [6:0] WRAP_BASE_BYTES = 7'h08;
	localparam int PAGE_IDX_W = 10;
	localparam int PAGE_ADDR_W = 9;
	localparam int PAGE_SMALL_W = 8;
	typedef enum logic [1:0] {
		FCB_ERASE_PARAM = 2'h0,
		FCB_ERASE_SECTOR = 2'h1,
		FCB_ERASE_BULK = 2'h2
	} fcb_erase_e;
endpackage

// >>> hw/fcb_byte_if.sv
// Byte-level link between the SPI front end and the register core.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface fcb_byte_if;
	logic rxValid;
	logic [7:0] rxByte;
	logic frameEnd;
	logic txLoad;
	logic [7:0] txByte;
	modport fe(output rxValid, output rxByte, output frameEnd,
		input txLoad, input txByte);
	modport core(input rxValid, input rxByte, input frameEnd,
		output txLoad, output txByte);
endinterface

// >>> hw/fcb_spi_front.sv
// SPI mode 0 front end: samples pins on core_clk, assembles bytes.
// Assumes the SPI clock runs at most an eighth of core_clk.
`timescale 1ns/1ps
module fcb_spi_front (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic spiSck,
	input wire logic spiCsN,
	input wire logic spiSi,
	output logic spiSo,
	output logic spiSoOe,
	fcb_byte_if.fe bus
);
	import fcb_pkg::*;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic sckPrev;
	logic csNPrev;
	logic [2:0] bitCnt;
	logic [7:0] rxShift;
	logic [7:0] txShift;
	wire sckS = sync2[0];
	wire csNS = sync2[1];
	wire siS = sync2[2];
	wire sckRise = sckS & ~sckPrev & ~csNS;
	wire sckFall = ~sckS & sckPrev & ~csNS;
	wire [7:0] rxNext = {rxShift[6:0], siS};

	always_ff @(posedge core_clk) begin
		sync1 <= {spiSi, spiCsN, spiSck};
		sync2 <= sync1;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sckPrev <= 1'b0;
			csNPrev <= 1'b1;
			bitCnt <= 3'h0;
			rxShift <= 8'h00;
			bus.rxValid <= 1'b0;
			bus.rxByte <= 8'h00;
			bus.frameEnd <= 1'b0;
		end else begin
			sckPrev <= sckS;
			csNPrev <= csNS;
			bus.frameEnd <= csNS & ~csNPrev;
			bus.rxValid <= sckRise && bitCnt == 3'h7;
			if (csNS) begin
				bitCnt <= 3'h0;
			end else if (sckRise) begin
				bitCnt <= bitCnt + 3'h1;
				rxShift <= rxNext;
				if (bitCnt == 3'h7) begin
					bus.rxByte <= rxNext;
				end
			end
		end
	end

	// Load lands between a rising edge and the next falling edge
	always_ff @(posedge core_clk) begin
		if (srst) begin
			txShift <= 8'h00;
			spiSo <= 1'b0;
			spiSoOe <= 1'b0;
		end else if (csNS) begin
			spiSoOe <= 1'b0;
		end else if (bus.txLoad) begin
			txShift <= bus.txByte;
			spiSoOe <= 1'b1;
		end else if (sckFall) begin
			spiSo <= txShift[7];
			txShift <= {txShift[6:0], 1'b0};
		end
	end
endmodule // fcb_spi_front

// >>> hw/fcb_erase_policy.sv
// Decides per erase request whether to erase, scan first, or skip.
// Assumes the erase engine reports the previous erase result and scans.
`timescale 1ns/1ps
module fcb_erase_policy (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic eraseReq,
	input wire logic blankCheckOn,
	input wire logic prevEraseOk,
	input wire logic scanZeroFound,
	input wire logic scanDone,
	output logic scanReq,
	output logic eraseStart,
	output logic eraseSkip
);
	import fcb_pkg::*;
	typedef enum logic [1:0] {
		FCB_EP_IDLE = 2'b01,
		FCB_EP_SCAN = 2'b10
	} fcb_ep_e;
	fcb_ep_e state;
	fcb_ep_e next_state;
	wire directErase = ~blankCheckOn | ~prevEraseOk;

	always_comb begin
		next_state = state;
		unique case (state)
			FCB_EP_IDLE: begin
				if (eraseReq && !directErase) next_state = FCB_EP_SCAN;
			end
			FCB_EP_SCAN: begin
				if (scanZeroFound || scanDone) next_state = FCB_EP_IDLE;
			end
			default: next_state = FCB_EP_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= FCB_EP_IDLE;
			eraseStart <= 1'b0;
			eraseSkip <= 1'b0;
		end else begin
			state <= next_state;
			eraseStart <= (state == FCB_EP_IDLE && eraseReq && directErase)
				|| (state == FCB_EP_SCAN && scanZeroFound);
			eraseSkip <= state == FCB_EP_SCAN && !scanZeroFound
				&& scanDone;
		end
	end

	assign scanReq = state == FCB_EP_SCAN;
endmodule // fcb_erase_policy

// >>> hw/fcb_cmd_config.sv
// Command-behaviour and burst/drive configuration of a serial flash.
// Assumes SPI pins from the host and an erase engine and read path on
// core_clk that consume the decoded settings.
`timescale 1ns/1ps
module fcb_cmd_config (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic spiSck,
	input wire logic spiCsN,
	input wire logic spiSi,
	output logic spiSo,
	output logic spiSoOe,
	input wire logic hwResetReq,
	input wire logic prevEraseOk,
	input wire logic scanZeroFound,
	input wire logic scanDone,
	output logic scanReq,
	output logic eraseStart,
	output logic eraseSkip,
	output fcb_pkg::fcb_erase_e eraseKind,
	output logic [fcb_pkg::ADDR_W-1:0] eraseAddr,
	output logic resumeCmd,
	output logic clearStatusCmd,
	output logic softResetPulse,
	input wire logic [fcb_pkg::PAGE_IDX_W-1:0] progByteIndex,
	output logic [fcb_pkg::PAGE_ADDR_W-1:0] progBufAddr,
	output logic paramSectorsPresent,
	input wire logic readMainArray,
	input wire logic readQuadIo,
	output logic wrapActive,
	output logic [6:0] wrapBytes,
	output logic [fcb_pkg::DRIVE_W-1:0] driveStrength
);
	import fcb_pkg::*;

	typedef enum logic [4:0] {
		FCB_ST_OPCODE = 5'b00001,
		FCB_ST_ADDR = 5'b00010,
		FCB_ST_DATA = 5'b00100,
		FCB_ST_READ = 5'b01000,
		FCB_ST_SKIP = 5'b10000
	} fcb_state_e;

	fcb_byte_if byteBus();

	fcb_state_e state;
	fcb_state_e next_state;
	logic [7:0] opcode;
	logic [ADDR_W-1:0] addrSr;
	logic [1:0] addrCnt;
	logic cmdComplete;
	logic resetArmed;
	logic eraseReq;
	logic hwSync1;
	logic hwSync2;
	logic [7:0] command_config_boot_copy;
	logic [7:0] command_config_volatile;
	logic [7:0] burst_drive_config_boot;
	logic [7:0] burst_drive_config_live;

	function automatic logic [7:0] regRead(
		input logic [ADDR_W-1:0] a,
		input logic [7:0] cmdBoot,
		input logic [7:0] cmdLive,
		input logic [7:0] burstBoot,
		input logic [7:0] burstLive
	);
		logic [7:0] r;
		r = 8'h00;
		if (a == ADDR_CMD_BOOT) r = cmdBoot & CMD_CFG_MASK;
		if (a == ADDR_CMD_LIVE) r = cmdLive & CMD_CFG_MASK;
		if (a == ADDR_BURST_BOOT) r = burstBoot & BURST_CFG_MASK;
		if (a == ADDR_BURST_LIVE) r = burstLive & BURST_CFG_MASK;
		return r;
	endfunction

	function automatic logic isAddrOp(input logic [7:0] op);
		return op == OP_READ_ANY || op == OP_WRITE_ANY
			|| op == OP_ERASE_PARAM || op == OP_ERASE_SECTOR;
	endfunction

	fcb_spi_front uFront (
		.core_clk(core_clk),
		.srst(srst),
		.spiSck(spiSck),
		.spiCsN(spiCsN),
		.spiSi(spiSi),
		.spiSo(spiSo),
		.spiSoOe(spiSoOe),
		.bus(byteBus.fe)
	);

	// Decoding of the received byte stream
	wire byteIn = byteBus.rxValid;
	wire [7:0] rxByte = byteBus.rxByte;
	wire [ADDR_W-1:0] fullAddr = {addrSr[ADDR_W-9:0], rxByte};
	wire lastAddr = state == FCB_ST_ADDR && byteIn
		&& addrCnt == 2'(ADDR_BYTES - 1);
	wire opHasAddr = isAddrOp(rxByte);
	wire opOneByte = rxByte == OP_RESUME_CLEAR || rxByte == OP_LEGACY_RESET
		|| rxByte == OP_RESET_ENABLE || rxByte == OP_RESET
		|| rxByte == OP_ERASE_BULK;
	wire [ADDR_W-1:0] readAddr = state == FCB_ST_READ ? addrSr : fullAddr;
	wire dataWrite = state == FCB_ST_DATA && byteIn;
	wire wrAny = dataWrite && opcode == OP_WRITE_ANY;
	wire wrCmdBoot = wrAny && addrSr == ADDR_CMD_BOOT;
	wire wrCmdLive = wrAny && addrSr == ADDR_CMD_LIVE;
	wire wrBurstBoot = wrAny && addrSr == ADDR_BURST_BOOT;
	wire wrBurstLive = (wrAny && addrSr == ADDR_BURST_LIVE)
		|| (dataWrite && opcode == OP_SET_BURST);
	wire frameEnd = byteBus.frameEnd;
	wire doSoftReset = frameEnd && cmdComplete
		&& ((opcode == OP_RESET && resetArmed)
		|| (opcode == OP_LEGACY_RESET
		&& command_config_volatile[BIT_LEGACY_RST]));
	wire reloadLive = doSoftReset || hwSync2;
	wire sectorMapBit = command_config_boot_copy[BIT_SECTOR_MAP];
	wire [7:0] mapBitMask = 8'(1 << BIT_SECTOR_MAP);
	wire [7:0] cmdWritable = CMD_CFG_MASK & ~mapBitMask;
	wire [WRAP_LEN_W-1:0] wrapCode = burst_drive_config_live[WRAP_LEN_W-1:0];
	wire wrapEnabled = ~burst_drive_config_live[BIT_WRAP_OFF];

	// Register read data goes out on the next falling SPI clock edge
	assign byteBus.txLoad = (lastAddr && opcode == OP_READ_ANY)
		|| (state == FCB_ST_READ && byteIn);
	assign byteBus.txByte = regRead(readAddr, command_config_boot_copy,
		command_config_volatile, burst_drive_config_boot,
		burst_drive_config_live);

	always_comb begin
		next_state = state;
		unique case (state)
			FCB_ST_OPCODE: begin
				if (byteIn) begin
					if (opHasAddr) next_state = FCB_ST_ADDR;
					else if (rxByte == OP_SET_BURST) next_state = FCB_ST_DATA;
					else next_state = FCB_ST_SKIP;
				end
			end
			FCB_ST_ADDR: begin
				if (lastAddr) begin
					if (opcode == OP_READ_ANY) next_state = FCB_ST_READ;
					else if (opcode == OP_WRITE_ANY) next_state = FCB_ST_DATA;
					else next_state = FCB_ST_SKIP;
				end
			end
			FCB_ST_DATA: begin
				if (byteIn) next_state = FCB_ST_SKIP;
			end
			FCB_ST_READ: next_state = FCB_ST_READ;
			FCB_ST_SKIP: next_state = FCB_ST_SKIP;
			default: next_state = FCB_ST_OPCODE;
		endcase
		if (frameEnd) next_state = FCB_ST_OPCODE;
	end

	// Hardware reset request is a pin: two stages before use
	always_ff @(posedge core_clk) begin
		hwSync1 <= hwResetReq;
		hwSync2 <= hwSync1;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= FCB_ST_OPCODE;
			opcode <= 8'h00;
			addrSr <= '0;
			addrCnt <= 2'h0;
			cmdComplete <= 1'b0;
		end else begin
			state <= next_state;
			if (frameEnd) begin
				addrCnt <= 2'h0;
				cmdComplete <= 1'b0;
			end else if (state == FCB_ST_OPCODE && byteIn) begin
				opcode <= rxByte;
				cmdComplete <= opOneByte;
			end else if (state == FCB_ST_ADDR && byteIn) begin
				addrSr <= fullAddr;
				addrCnt <= addrCnt + 2'h1;
				cmdComplete <= lastAddr;
			end else if (byteIn && state != FCB_ST_READ) begin
				// Extra bytes spoil one-byte commands
				cmdComplete <= 1'b0;
			end
		end
	end

	// Frame-level actions fire when chip select rises on a whole command
	always_ff @(posedge core_clk) begin
		if (srst) begin
			resetArmed <= 1'b0;
			resumeCmd <= 1'b0;
			clearStatusCmd <= 1'b0;
			softResetPulse <= 1'b0;
			eraseReq <= 1'b0;
			eraseKind <= FCB_ERASE_SECTOR;
			eraseAddr <= '0;
		end else begin
			resumeCmd <= 1'b0;
			clearStatusCmd <= 1'b0;
			eraseReq <= 1'b0;
			softResetPulse <= doSoftReset;
			if (frameEnd) begin
				resetArmed <= cmdComplete && opcode == OP_RESET_ENABLE;
				if (cmdComplete && opcode == OP_RESUME_CLEAR) begin
					resumeCmd <= command_config_volatile[BIT_RESUME_SEL];
					clearStatusCmd <= ~command_config_volatile[BIT_RESUME_SEL];
				end
				if (cmdComplete && (opcode == OP_ERASE_PARAM
					|| opcode == OP_ERASE_SECTOR
					|| opcode == OP_ERASE_BULK)) begin
					eraseReq <= 1'b1;
					eraseAddr <= opcode == OP_ERASE_BULK ? '0 : addrSr;
					if (opcode == OP_ERASE_PARAM) eraseKind <= FCB_ERASE_PARAM;
					else if (opcode == OP_ERASE_BULK) eraseKind <= FCB_ERASE_BULK;
					else eraseKind <= FCB_ERASE_SECTOR;
				end
			end
		end
	end

	// Boot copies stand in for non-volatile cells; srst is power-on
	always_ff @(posedge core_clk) begin
		if (srst) begin
			command_config_boot_copy <= CMD_CFG_BOOT_RESET;
			burst_drive_config_boot <= BURST_CFG_BOOT_RESET;
		end else begin
			if (wrCmdBoot) begin
				command_config_boot_copy <= rxByte & CMD_CFG_MASK;
			end
			if (wrBurstBoot) begin
				burst_drive_config_boot <= rxByte & BURST_CFG_MASK;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			command_config_volatile <= CMD_CFG_BOOT_RESET;
			burst_drive_config_live <= BURST_CFG_BOOT_RESET;
		end else if (reloadLive) begin
			command_config_volatile <= command_config_boot_copy;
			burst_drive_config_live <= burst_drive_config_boot;
		end else begin
			if (wrCmdLive) begin
				// Map bit is kept; host data for it is dropped
				command_config_volatile <= (rxByte & cmdWritable)
					| (command_config_volatile & mapBitMask);
			end else if (wrCmdBoot) begin
				command_config_volatile[BIT_SECTOR_MAP] <=
					rxByte[BIT_SECTOR_MAP];
			end
			if (wrBurstLive) begin
				burst_drive_config_live <= rxByte & BURST_CFG_MASK;
			end
		end
	end

	// Settings handed to the program, erase and read paths
	always_ff @(posedge core_clk) begin
		if (srst) begin
			progBufAddr <= '0;
			wrapActive <= 1'b0;
			wrapBytes <= WRAP_BASE_BYTES;
		end else begin
			if (command_config_volatile[BIT_PAGE_WRAP]) begin
				progBufAddr <= progByteIndex[PAGE_ADDR_W-1:0];
			end else begin
				progBufAddr <= {1'b0, progByteIndex[PAGE_SMALL_W-1:0]};
			end
			wrapActive <= wrapEnabled && readMainArray
				&& readQuadIo;
			wrapBytes <= WRAP_BASE_BYTES << wrapCode;
		end
	end

	assign paramSectorsPresent =
		~command_config_volatile[BIT_SECTOR_MAP];
	assign driveStrength =
		burst_drive_config_live[DRIVE_LSB +: DRIVE_W];

	fcb_erase_policy uErase (
		.core_clk(core_clk),
		.srst(srst),
		.eraseReq(eraseReq),
		.blankCheckOn(command_config_volatile[BIT_BLANK_CHECK]),
		.prevEraseOk(prevEraseOk),
		.scanZeroFound(scanZeroFound),
		.scanDone(scanDone),
		.scanReq(scanReq),
		.eraseStart(eraseStart),
		.eraseSkip(eraseSkip)
	);
endmodule // fcb_cmd_config

// >>> dv/fcb_cmd_config_properties.sv
// Port-level assertions for the command-behaviour configuration block.
// Assumes a single core_clk domain with synchronous active-high srst.
`timescale 1ns/1ps
module fcb_cmd_config_properties (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic spiCsN,
	input wire logic scanZeroFound,
	input wire logic scanDone,
	input wire logic scanReq,
	input wire logic eraseStart,
	input wire logic eraseSkip,
	input wire logic resumeCmd,
	input wire logic clearStatusCmd,
	input wire logic softResetPulse,
	input wire logic [fcb_pkg::PAGE_IDX_W-1:0] progByteIndex,
	input wire logic [fcb_pkg::PAGE_ADDR_W-1:0] progBufAddr,
	input wire logic readMainArray,
	input wire logic readQuadIo,
	input wire logic wrapActive,
	input wire logic [6:0] wrapBytes
);
	import fcb_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// Low byte always follows the index; bit 8 can only come from the index
	property p_page_wrap;
		!$past(srst) |-> progBufAddr[7:0] == $past(progByteIndex[7:0])
			&& (!progBufAddr[8] || $past(progByteIndex[8]));
	endproperty
	property p_wrap_cause;
		wrapActive |-> $past(readMainArray) && $past(readQuadIo);
	endproperty
	property p_wrap_len;
		$onehot(wrapBytes) && wrapBytes[2:0] == 3'h0;
	endproperty
	property p_scan_zero;
		scanReq && scanZeroFound |=> eraseStart;
	endproperty
	property p_scan_done;
		scanReq && scanDone && !scanZeroFound |=> eraseSkip && !eraseStart;
	endproperty
	property p_skip_cause;
		eraseSkip |-> $past(scanReq) && $past(scanDone);
	endproperty
	property p_start_single;
		eraseStart |=> !eraseStart && !eraseSkip;
	endproperty
	property p_resume_excl;
		resumeCmd || clearStatusCmd |-> spiCsN && !(resumeCmd && clearStatusCmd)
			##1 !(resumeCmd || clearStatusCmd);
	endproperty
	property p_reset_frame;
		softResetPulse |-> spiCsN ##1 !softResetPulse;
	endproperty
	a_page_wrap: assert property (p_page_wrap)
		else $error("page buffer address does not follow index");
	a_wrap_cause: assert property (p_wrap_cause)
		else $error("wrap active outside quad main array read");
	a_wrap_len: assert property (p_wrap_len)
		else $error("wrap length not 8, 16, 32 or 64");
	a_scan_zero: assert property (p_scan_zero)
		else $error("zero found without erase start");
	a_scan_done: assert property (p_scan_done)
		else $error("blank sector without erase skip");
	a_skip_cause: assert property (p_skip_cause)
		else $error("erase skip without finished scan");
	a_start_single: assert property (p_start_single)
		else $error("erase start longer than one cycle");
	a_resume_excl: assert property (p_resume_excl)
		else $error("resume and clear status not exclusive pulses");
	a_reset_frame: assert property (p_reset_frame)
		else $error("software reset inside frame or too long");
	c_skip: cover property (eraseSkip);
	c_resume: cover property (resumeCmd);
	c_reset: cover property (softResetPulse);
	c_wrap: cover property (wrapActive);
endmodule // fcb_cmd_config_properties

// >>> dv/fcb_spi_host.sv
// SPI mode 0 host model that sends whole command frames.
// Assumes core_clk from the bench; pins change at its falling edge.
`timescale 1ns/1ps
module fcb_spi_host (
	input wire logic core_clk,
	input wire logic spiSo,
	input wire logic spiSoOe,
	output logic spiSck,
	output logic spiCsN,
	output logic spiSi
);
	// Half of the 320 ns link period in 40 ns core cycles
	localparam int HALF = 4;
	initial begin
		spiSck = 1'b0;
		spiCsN = 1'b1;
		spiSi = 1'b0;
	end
	task automatic shift(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			spiSi = b[i];
			repeat (HALF) @(negedge core_clk);
			spiSck = 1'b1;
			// An undriven output line reads as the inverse of its last level
			r = {r[6:0], spiSoOe ? spiSo : ~spiSo};
			repeat (HALF) @(negedge core_clk);
			spiSck = 1'b0;
		end
	endtask
	task automatic xfer(input logic [7:0] tx[$], input int nRd,
		output logic [7:0] rd);
		logic [7:0] junk;
		@(negedge core_clk);
		spiCsN = 1'b0;
		repeat (HALF) @(negedge core_clk);
		foreach (tx[i]) shift(tx[i], junk);
		repeat (nRd) shift(8'h5a, rd);
		repeat (HALF) @(negedge core_clk);
		spiCsN = 1'b1;
		// Deselected line must not keep looking like the last bit
		spiSi = ~spiSi;
		repeat (16) @(negedge core_clk);
	endtask
endmodule // fcb_spi_host

// >>> dv/fcb_cmd_config_test.sv
// Self-checking bench for the command-behaviour configuration block.
// Assumes the SPI host model and the port checker bound below.
`timescale 1ns/1ps
module fcb_cmd_config_test;
	import fcb_pkg::*;
	logic core_clk, srst, spiSck, spiCsN, spiSi, spiSo, spiSoOe, hwResetReq;
	logic prevEraseOk, scanZeroFound, scanDone, scanReq, eraseStart, eraseSkip;
	logic resumeCmd, clearStatusCmd, softResetPulse, paramSectorsPresent;
	logic readMainArray, readQuadIo, wrapActive;
	fcb_erase_e eraseKind;
	logic [ADDR_W-1:0] eraseAddr;
	logic [PAGE_IDX_W-1:0] progByteIndex;
	logic [PAGE_ADDR_W-1:0] progBufAddr;
	logic [6:0] wrapBytes;
	logic [DRIVE_W-1:0] driveStrength;
	int mismatches, checks, nRes, nClr, nRst, nStart, nSkip;
	logic [7:0] rdJunk;
	fcb_cmd_config dut (.core_clk(core_clk), .srst(srst), .spiSck(spiSck),
		.spiCsN(spiCsN), .spiSi(spiSi), .spiSo(spiSo), .spiSoOe(spiSoOe),
		.hwResetReq(hwResetReq), .prevEraseOk(prevEraseOk),
		.scanZeroFound(scanZeroFound), .scanDone(scanDone), .scanReq(scanReq),
		.eraseStart(eraseStart), .eraseSkip(eraseSkip), .eraseKind(eraseKind),
		.eraseAddr(eraseAddr), .resumeCmd(resumeCmd),
		.clearStatusCmd(clearStatusCmd), .softResetPulse(softResetPulse),
		.progByteIndex(progByteIndex), .progBufAddr(progBufAddr),
		.paramSectorsPresent(paramSectorsPresent),
		.readMainArray(readMainArray), .readQuadIo(readQuadIo),
		.wrapActive(wrapActive), .wrapBytes(wrapBytes),
		.driveStrength(driveStrength));
	fcb_spi_host host (.core_clk(core_clk), .spiSo(spiSo),
		.spiSoOe(spiSoOe), .spiSck(spiSck), .spiCsN(spiCsN), .spiSi(spiSi));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Pulses are counted at the falling edge, where they have settled
	always @(negedge core_clk) begin
		if (resumeCmd === 1'b1) nRes++;
		if (clearStatusCmd === 1'b1) nClr++;
		if (softResetPulse === 1'b1) nRst++;
		if (eraseStart === 1'b1) nStart++;
		if (eraseSkip === 1'b1) nSkip++;
	end
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic [7:0] c);
		logic [7:0] r;
		host.xfer('{c}, 0, r);
	endtask
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		logic [7:0] r;
		host.xfer('{OP_WRITE_ANY, a[23:16], a[15:8], a[7:0], d}, 0, r);
	endtask
	task automatic rdChk(input logic [23:0] a, input logic [7:0] e);
		logic [7:0] r;
		host.xfer('{OP_READ_ANY, a[23:16], a[15:8], a[7:0]}, 1, r);
		check(r, e);
	endtask
	task automatic t_regs;
		rdChk(ADDR_CMD_BOOT, 8'h00);
		rdChk(ADDR_BURST_BOOT, 8'h10);
		rdChk(ADDR_CMD_LIVE, 8'h00);
		rdChk(ADDR_BURST_LIVE, 8'h10);
		check(driveStrength, 3'h0);
		check(paramSectorsPresent, 1'b1);
		rdChk(24'h000010, 8'h00);
		progByteIndex = 10'h1ab;
		repeat (2) @(negedge core_clk);
		check(progBufAddr, 9'h0ab);
		// Map bit written equal to its boot copy, as the host must
		wr(ADDR_CMD_LIVE, 8'hf7);
		rdChk(ADDR_CMD_LIVE, 8'h35);
		check(progBufAddr, 9'h1ab);
	endtask
	task automatic t_resume;
		op(OP_RESUME_CLEAR);
		check(nRes, 1);
		wr(ADDR_CMD_LIVE, 8'h00);
		op(OP_RESUME_CLEAR);
		check(nClr, 1);
		check(nRes, 1);
	endtask
	task automatic t_burst;
		readMainArray = 1'b1;
		readQuadIo = 1'b1;
		for (int k = 0; k < 4; k++) begin
			host.xfer('{OP_SET_BURST, {6'h00, k[1:0]}}, 0, rdJunk);
			rdChk(ADDR_BURST_LIVE, {6'h00, k[1:0]});
			check(wrapBytes, 7'h08 << k);
			check(wrapActive, 1'b1);
		end
		readMainArray = 1'b0;
		repeat (2) @(negedge core_clk);
		check(wrapActive, 1'b0);
		readMainArray = 1'b1;
		readQuadIo = 1'b0;
		repeat (2) @(negedge core_clk);
		check(wrapActive, 1'b0);
		readQuadIo = 1'b1;
		wr(ADDR_BURST_LIVE, 8'hff);
		rdChk(ADDR_BURST_LIVE, 8'hf3);
		check(driveStrength, 3'h7);
		check(wrapActive, 1'b0);
	endtask
	task automatic t_soft_reset;
		op(OP_LEGACY_RESET);
		op(OP_RESET);
		check(nRst, 0);
		op(OP_RESET_ENABLE);
		op(OP_RESET);
		check(nRst, 1);
		rdChk(ADDR_BURST_LIVE, 8'h10);
		check(driveStrength, 3'h0);
		wr(ADDR_CMD_LIVE, 8'h01);
		op(OP_LEGACY_RESET);
		check(nRst, 2);
		rdChk(ADDR_CMD_LIVE, 8'h00);
		wr(ADDR_BURST_LIVE, 8'h02);
		hwResetReq = 1'b1;
		repeat (8) @(negedge core_clk);
		hwResetReq = 1'b0;
		rdChk(ADDR_BURST_LIVE, 8'h10);
	endtask
	task automatic t_map;
		wr(ADDR_CMD_BOOT, 8'h08);
		rdChk(ADDR_CMD_LIVE, 8'h08);
		check(paramSectorsPresent, 1'b0);
	endtask
	task automatic t_erase;
		host.xfer('{OP_ERASE_PARAM, 8'h12, 8'h34, 8'h56}, 0, rdJunk);
		check(nStart, 1);
		check(eraseKind, FCB_ERASE_PARAM);
		check(eraseAddr, 24'h123456);
		wr(ADDR_CMD_LIVE, 8'h28);
		prevEraseOk = 1'b0;
		host.xfer('{OP_ERASE_SECTOR, 8'h01, 8'h00, 8'h00}, 0, rdJunk);
		check(nStart, 2);
		check(eraseKind, FCB_ERASE_SECTOR);
		prevEraseOk = 1'b1;
		for (int k = 0; k < 2; k++) begin
			op(OP_ERASE_BULK);
			check(scanReq, 1'b1);
			check(nStart, 2 + k);
			scanZeroFound = (k == 0);
			scanDone = (k == 1);
			@(negedge core_clk);
			scanZeroFound = 1'b0;
			scanDone = 1'b0;
			repeat (3) @(negedge core_clk);
		end
		check(nStart, 3);
		check(nSkip, 1);
		check(eraseKind, FCB_ERASE_BULK);
		check(eraseAddr, 24'h000000);
	endtask
	task automatic end_of_test;
		if (mismatches == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		hwResetReq = 1'b0;
		prevEraseOk = 1'b1;
		scanZeroFound = 1'b0;
		scanDone = 1'b0;
		progByteIndex = '0;
		readMainArray = 1'b0;
		readQuadIo = 1'b0;
		repeat (4) @(negedge core_clk);
		srst = 1'b0;
		repeat (4) @(negedge core_clk);
		t_regs;
		t_resume;
		t_burst;
		t_soft_reset;
		t_map;
		t_erase;
		end_of_test;
	end
	// About 40 frames of at most 400 cycles each
	initial begin
		repeat (40000) @(posedge core_clk);
		mismatches++;
		end_of_test;
	end
endmodule // fcb_cmd_config_test
bind fcb_cmd_config fcb_cmd_config_properties u_props (
	.core_clk(core_clk),
	.srst(srst),
	.spiCsN(spiCsN),
	.scanZeroFound(scanZeroFound),
	.scanDone(scanDone),
	.scanReq(scanReq),
	.eraseStart(eraseStart),
	.eraseSkip(eraseSkip),
	.resumeCmd(resumeCmd),
	.clearStatusCmd(clearStatusCmd),
	.softResetPulse(softResetPulse),
	.progByteIndex(progByteIndex),
	.progBufAddr(progBufAddr),
	.readMainArray(readMainArray),
	.readQuadIo(readQuadIo),
	.wrapActive(wrapActive),
	.wrapBytes(wrapBytes)
);
